/* File: verilog/nmreq_map.svh */
`ifndef NMREQ_MAP_SVH
`define NMREQ_MAP_SVH
`define NMREQ_PORT_CODE     8'hF2
`define NMREQ_SLAVE_MAX_MB  7'd99
`define NMREQ_SLAVE_MAX_ALT 7'd90
`define NMREQ_BYTES_MIN     8'd1
`define NMREQ_BYTES_MAX     8'd128
`define NMREQ_CR_START      16'hC00
`define NMREQ_COIL_MODE     16'h0001
`define NMREQ_HOLD_MODE     17'h09C41
`define NMREQ_TIMEOUT_MS    800
`define NMREQ_CLK_HZ        20000000
`define NMREQ_TIMEOUT_CYC   ((`NMREQ_TIMEOUT_MS * (`NMREQ_CLK_HZ / 1000)))
`endif

/* File: verilog/nmreq_pkg.sv */
`default_nettype none
package nmreq_pkg;
  typedef enum logic [2:0] {
    NMREQ_IDLE  = 3'b000,
    NMREQ_SEND  = 3'b001,
    NMREQ_WAIT  = 3'b011,
    NMREQ_RECV  = 3'b010,
    NMREQ_DONE  = 3'b110
  } nmreq_state_e;
  typedef logic [15:0] nmreq_word_t;
endpackage : nmreq_pkg
`default_nettype wire

/* File: verilog/nmreq_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module nmreq_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         clr,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  initial begin
    if (D < 2 || (1 << AW) != D) $error("depth must be a power of two");
  end
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;
  assign in_ready  = (wp_q - rp_q) != (AW+1)'(D);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (clr) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop)  rp_q <= rp_q + 1'b1;
    end
  end
endmodule : nmreq_fifo
`default_nettype wire

/* File: verilog/nmreq_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nmreq_map.svh"
module nmreq_top
  import nmreq_pkg::*;
#(
  parameter int TIMEOUT_CYC = `NMREQ_TIMEOUT_CYC,
  parameter int MEM_WORDS   = 256,
  parameter int FIFO_DEPTH  = 16
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // command from program
  input  wire logic        cmd_start,
  input  wire logic        cmd_write,
  input  wire logic [15:0] cmd_desc,
  input  wire logic [7:0]  cmd_bytes_bcd,
  input  wire logic [15:0] cmd_local_oct,
  input  wire logic [15:0] cmd_remote_addr,
  input  wire logic [2:0]  cmd_remote_type,
  input  wire logic        cmd_alt_net,
  output logic             cmd_accept,
  // status
  output logic             port_busy_flag,
  output logic             port_error_flag,
  // request to rtu framer
  output logic             req_valid,
  input  wire logic        req_ready,
  output logic             req_write,
  output logic [6:0]       req_slave,
  output logic [15:0]      req_remote_addr,
  output logic [2:0]       req_remote_type,
  output logic [7:0]       req_bytes,
  // write data to framer
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // response from framer
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic        rx_done,
  input  wire logic        rx_fault,
  // local word memory load and read ports
  input  wire logic        mem_load_we,
  input  wire logic [15:0] mem_load_addr,
  input  wire logic [15:0] mem_load_data,
  input  wire logic [15:0] mem_rd_addr,
  output logic [15:0]      mem_rd_data,
  // address arithmetic helpers
  input  wire logic [15:0] map_index_oct,
  output logic [15:0]      map_coil_addr,
  output logic [16:0]      map_hold_addr
);
  localparam int AW = $clog2(MEM_WORDS);
  initial begin
    if (MEM_WORDS < 2 || FIFO_DEPTH < 2 || TIMEOUT_CYC < 1) $error("bad parameters");
    if ((1 << AW) != MEM_WORDS) $error("memory depth must be a power of two");
  end
  // ----------------------------------------------------------------
  // conversions
  // ----------------------------------------------------------------
  function automatic logic [15:0] oct2bin(input logic [15:0] o);
    logic [15:0] r;
    r = '0;
    for (int i = 5; i >= 0; i--) begin
      r = 16'((r << 3) | 16'(o[i*3 +: 3] & 3'h7));
    end
    return r;
  endfunction : oct2bin
  function automatic logic [7:0] bcd2bin(input logic [7:0] b);
    return 8'(b[7:4]) * 8'd10 + 8'(b[3:0]);
  endfunction : bcd2bin
  function automatic logic bcd_ok(input logic [7:0] b);
    return (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
  endfunction : bcd_ok
  wire [15:0] idx_bin = oct2bin(map_index_oct);
  assign map_coil_addr = idx_bin + `NMREQ_CR_START + `NMREQ_COIL_MODE;
  assign map_hold_addr = 17'(idx_bin) + `NMREQ_HOLD_MODE;
  // byte count: an 8-bit bcd tops out at 99, so 00 stands for the full 128 bytes;
  // counts 100..127 cannot be asked for
  wire [7:0] slave_bin = bcd2bin(cmd_desc[7:0]);
  wire [7:0] cnt_bin   = bcd2bin(cmd_bytes_bcd);
  wire [7:0] cnt_full  = (cmd_bytes_bcd == 8'h00) ? `NMREQ_BYTES_MAX : cnt_bin;
  wire [6:0] slave_max = cmd_alt_net ? `NMREQ_SLAVE_MAX_ALT : `NMREQ_SLAVE_MAX_MB;
  wire desc_ok = (cmd_desc[15:8] == `NMREQ_PORT_CODE) && bcd_ok(cmd_desc[7:0])
               && slave_bin != 8'd0 && slave_bin <= {1'b0, slave_max};
  wire cnt_ok  = bcd_ok(cmd_bytes_bcd) && cnt_full >= `NMREQ_BYTES_MIN
               && cnt_full <= `NMREQ_BYTES_MAX;
  wire type_ok = cmd_remote_type != 3'd0 && cmd_remote_type <= 3'd4;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  nmreq_state_e  st_q;
  logic [AW-1:0] base_q;
  logic [7:0]    cnt_q;
  logic [7:0]    txi_q;
  logic [7:0]    rxi_q;
  logic [31:0]   tmo_q;
  nmreq_word_t   mem [MEM_WORDS];
  wire idle = (st_q == NMREQ_IDLE);
  assign cmd_accept = cmd_start && idle;
  wire   cmd_good   = desc_ok && cnt_ok && type_ok;
  // fifo between memory and framer (write path) / framer and memory (read path)
  logic [7:0] f_in_data;
  logic       f_in_valid;
  logic       f_in_ready;
  logic [7:0] f_out_data;
  logic       f_out_valid;
  logic       f_out_ready;
  nmreq_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .clr       (cmd_accept),
    .in_data   (f_in_data),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );
  wire [AW-1:0] tx_word = AW'(base_q + AW'(txi_q >> 1));
  nmreq_word_t  tx_w;
  assign tx_w = mem[tx_word];
  wire sending = (st_q == NMREQ_SEND) && req_write;
  wire receiving = (st_q == NMREQ_RECV) || (st_q == NMREQ_WAIT && !req_write);
  // write: low byte then high byte of each word, consecutive words
  assign f_in_data  = sending ? (txi_q[0] ? tx_w[15:8] : tx_w[7:0]) : rx_data;
  assign f_in_valid = sending ? (txi_q < cnt_q) : (receiving && rx_valid && rxi_q < cnt_q);
  assign rx_ready   = receiving && f_in_ready;
  assign tx_data    = f_out_data;
  assign tx_valid   = req_write && f_out_valid;
  assign f_out_ready = req_write ? tx_ready : 1'b1;
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= NMREQ_IDLE;
    end else begin
      case (st_q)
        NMREQ_IDLE: if (cmd_accept && cmd_good) st_q <= NMREQ_SEND;
        NMREQ_SEND: if (req_ready && (!req_write || txi_q >= cnt_q)) st_q <= NMREQ_WAIT;
        NMREQ_WAIT: begin
          if (rx_fault || tmo_q == 32'd1) st_q <= NMREQ_DONE;
          // a write answer carries no bytes, so its done pulse ends the exchange here
          else if (rx_done) st_q <= NMREQ_DONE;
          else if (rx_valid) st_q <= NMREQ_RECV;
        end
        NMREQ_RECV: if (rx_fault || (rx_done && !f_out_valid)) st_q <= NMREQ_DONE;
        NMREQ_DONE: st_q <= NMREQ_IDLE;
        default:    st_q <= NMREQ_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      base_q          <= '0;
      cnt_q           <= 8'h00;
      req_write       <= 1'b0;
      req_slave       <= 7'h00;
      req_remote_addr <= 16'h0000;
      req_remote_type <= 3'h0;
    end else if (cmd_accept) begin
      base_q          <= AW'(oct2bin(cmd_local_oct));
      cnt_q           <= cnt_full;
      req_write       <= cmd_write;
      req_slave       <= slave_bin[6:0];
      req_remote_addr <= cmd_remote_addr;
      req_remote_type <= cmd_remote_type;
    end
  end
  assign req_bytes = cnt_q;
  // request held until framer takes it; framing itself is rtu
  assign req_valid = (st_q == NMREQ_SEND) && (!req_write || txi_q >= cnt_q);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txi_q <= 8'h00;
    end else if (cmd_accept) begin
      txi_q <= 8'h00;
    end else if (sending && f_in_valid && f_in_ready) begin
      txi_q <= txi_q + 8'h01;
    end
  end
  // the timeout only guards the wait for a first answer; a slave that stalls
  // mid-response is left to the framer's own fault detection
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tmo_q <= 32'd0;
    end else if (st_q != NMREQ_WAIT) begin
      tmo_q <= 32'(TIMEOUT_CYC);
    end else if (tmo_q != 32'd0) begin
      tmo_q <= tmo_q - 32'd1;
    end
  end
  // ----------------------------------------------------------------
  // memory: read path drains fifo into consecutive bytes
  // ----------------------------------------------------------------
  wire          rx_pop  = !req_write && f_out_valid;
  wire [AW-1:0] rx_word = AW'(base_q + AW'(rxi_q >> 1));
  always_ff @(posedge clock) begin
    if (rx_pop) begin
      if (rxi_q[0]) mem[rx_word][15:8] <= f_out_data;
      else          mem[rx_word][7:0]  <= f_out_data;
    end else if (mem_load_we) begin
      mem[AW'(mem_load_addr)] <= mem_load_data;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxi_q <= 8'h00;
    end else if (cmd_accept) begin
      rxi_q <= 8'h00;
    end else if (rx_pop) begin
      rxi_q <= rxi_q + 8'h01;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) mem_rd_data <= 16'h0000;
    else        mem_rd_data <= mem[AW'(mem_rd_addr)];
  end
  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  wire fault_ev = (st_q == NMREQ_WAIT && tmo_q == 32'd1) || ((st_q == NMREQ_WAIT
                || st_q == NMREQ_RECV) && rx_fault) || (cmd_accept && !cmd_good);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)         port_error_flag <= 1'b0;
    else if (fault_ev)  port_error_flag <= 1'b1;
    else if (cmd_accept) port_error_flag <= 1'b0;
  end
  assign port_busy_flag = !idle;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_BUSY_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
    (st_q != NMREQ_IDLE && st_q != NMREQ_DONE) |=> port_busy_flag) else $error("busy dropped");
  AST_ONE_AT_A_TIME: assert property (@(posedge clock) disable iff (!rst_b)
    port_busy_flag |-> !cmd_accept ##1 ($stable(req_slave) && $stable(req_bytes)))
    else $error("accepted while busy");
  AST_TIMEOUT: assert property (@(posedge clock) disable iff (!rst_b)
    (st_q == NMREQ_WAIT && tmo_q == 32'd1 && !rx_fault) |=> port_error_flag)
    else $error("timeout not logged");
  AST_ERR_CLR: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_accept && cmd_good) |=> !port_error_flag) else $error("error not cleared");
  AST_BAD_DESC: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_accept && !desc_ok) |=> (st_q == NMREQ_IDLE && port_error_flag))
    else $error("bad descriptor run");
  AST_SLAVE_MAX: assert property (@(posedge clock) disable iff (!rst_b)
    req_valid |-> (req_slave != 7'd0 && req_slave <= `NMREQ_SLAVE_MAX_MB))
    else $error("slave out of range");
  AST_CNT: assert property (@(posedge clock) disable iff (!rst_b)
    req_valid |-> (req_bytes >= 8'd1 && req_bytes <= 8'd128)) else $error("bad count");
  AST_WR_ALL: assert property (@(posedge clock) disable iff (!rst_b)
    (req_valid && req_write) |-> txi_q == cnt_q) else $error("write short");
  AST_COIL: assert property (@(posedge clock) disable iff (!rst_b)
    (map_index_oct == 16'h002C) |-> map_coil_addr == 16'd3117) else $error("coil map");
  COV_WRITE: cover property (@(posedge clock) disable iff (!rst_b)
    req_valid && req_ready && req_write);
  COV_READ: cover property (@(posedge clock) disable iff (!rst_b)
    st_q == NMREQ_RECV ##1 st_q == NMREQ_DONE);
  COV_TMO: cover property (@(posedge clock) disable iff (!rst_b)
    st_q == NMREQ_WAIT && tmo_q == 32'd1);
  // map checks key on fixed index points that the bench holds only 1 ns between clock edges, so none is sampled
  AST_HOLD_MAP: assert property (@(posedge clock) disable iff (!rst_b)
    (map_index_oct == 16'h0440) |-> map_hold_addr == 17'd41089) else $error("hold map");
  AST_REQ_HELD: assert property (@(posedge clock) disable iff (!rst_b)
    (req_valid && !req_ready) |=> req_valid) else $error("request dropped");
  AST_TYPE: assert property (@(posedge clock) disable iff (!rst_b)
    req_valid |-> (req_remote_type != 3'd0 && req_remote_type <= 3'd4))
    else $error("bad type");
  AST_BUSY_ON: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_accept && cmd_good) |=> port_busy_flag) else $error("busy not raised");
  AST_FAULT_ERR: assert property (@(posedge clock) disable iff (!rst_b)
    ((st_q == NMREQ_WAIT || st_q == NMREQ_RECV) && rx_fault) |=> port_error_flag)
    else $error("fault not logged");
  AST_CNT_BAD: assert property (@(posedge clock) disable iff (!rst_b)
    (cmd_accept && !cnt_ok) |=> port_error_flag) else $error("bad count taken");
  COV_FAULT: cover property (@(posedge clock) disable iff (!rst_b)
    st_q == NMREQ_WAIT && rx_fault);
  COV_REFUSE: cover property (@(posedge clock) disable iff (!rst_b)
    cmd_accept && !cmd_good);
endmodule : nmreq_top
`default_nettype wire

/* File: tb/nmreq_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nmreq_slave_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // behaviour: 0 answer, 1 fault, 2 silent; lag delays the request handshake
  input  wire logic [1:0]  mode,
  input  wire logic [3:0]  lag,
  // request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [6:0]  req_slave,
  input  wire logic [15:0] req_remote_addr,
  input  wire logic [2:0]  req_remote_type,
  input  wire logic [7:0]  req_bytes,
  // write bytes
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  // response
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic             rx_done,
  output logic             rx_fault
);
  logic [7:0]  cap [0:15];
  logic [34:0] seen_req;
  int          cap_n = 0;
  int          n_done;
  int          k;

  always @(posedge clock) if (rst_b && tx_valid && tx_ready) begin
    cap[cap_n[3:0]] <= tx_data;
    cap_n <= cap_n + 1;
  end

  initial begin
    {req_ready, tx_ready, rx_valid, rx_done, rx_fault} = 5'h00;
    rx_data = 8'h5A;
    n_done = 0;
    @(posedge clock iff rst_b);
    tx_ready <= 1'b1;
    forever begin
      // only ever answers a request the master raised
      @(posedge clock iff req_valid);
      seen_req = {req_write, req_slave, req_remote_type, req_remote_addr, req_bytes};
      repeat (lag) @(posedge clock);
      req_ready <= 1'b1;
      @(posedge clock);
      req_ready <= 1'b0;
      if (mode == 2'h1) begin
        repeat (3) @(posedge clock);
        rx_fault <= 1'b1;
        @(posedge clock);
        rx_fault <= 1'b0;
      end else if (mode == 2'h0) begin
        if (!seen_req[34]) begin
          for (k = 0; k < int'(req_bytes); k++) begin
            rx_valid <= 1'b1;
            rx_data  <= 8'(8'h11 * (k + 1));
            @(posedge clock iff rx_ready);
          end
          rx_valid <= 1'b0;
          // released data line must not keep looking valid
          rx_data  <= ~rx_data;
        end
        repeat (2) @(posedge clock);
        rx_done <= 1'b1;
        @(posedge clock);
        rx_done <= 1'b0;
        n_done++;
      end
    end
  end
endmodule : nmreq_slave_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nmreq_pkg::*;
  localparam int TMO = 50;
  logic        clock, rst_b, cmd_start, cmd_write, cmd_alt_net, cmd_accept;
  logic [15:0] cmd_desc, cmd_local_oct, cmd_remote_addr, mem_load_addr, mem_load_data;
  logic [15:0] mem_rd_addr, mem_rd_data, map_index_oct, map_coil_addr, req_remote_addr;
  logic [7:0]  cmd_bytes_bcd, req_bytes, tx_data, rx_data;
  logic [2:0]  cmd_remote_type, req_remote_type;
  logic [6:0]  req_slave;
  logic [16:0] map_hold_addr;
  logic        port_busy_flag, port_error_flag, req_valid, req_ready, req_write, tx_valid;
  logic        tx_ready, rx_valid, rx_ready, rx_done, rx_fault, mem_load_we;
  logic [1:0]  mode;
  logic [3:0]  lag;
  int          n_errors, cmp_count, waited, i;

  nmreq_top #(.TIMEOUT_CYC(TMO)) uut (.clock(clock), .rst_b(rst_b), .cmd_start(cmd_start),
    .cmd_write(cmd_write), .cmd_desc(cmd_desc), .cmd_bytes_bcd(cmd_bytes_bcd),
    .cmd_local_oct(cmd_local_oct), .cmd_remote_addr(cmd_remote_addr),
    .cmd_remote_type(cmd_remote_type), .cmd_alt_net(cmd_alt_net), .cmd_accept(cmd_accept),
    .port_busy_flag(port_busy_flag), .port_error_flag(port_error_flag),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_slave(req_slave), .req_remote_addr(req_remote_addr),
    .req_remote_type(req_remote_type), .req_bytes(req_bytes), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_done(rx_done), .rx_fault(rx_fault), .mem_load_we(mem_load_we),
    .mem_load_addr(mem_load_addr), .mem_load_data(mem_load_data),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .map_index_oct(map_index_oct),
    .map_coil_addr(map_coil_addr), .map_hold_addr(map_hold_addr));

  nmreq_slave_model pm (.clock(clock), .rst_b(rst_b), .mode(mode), .lag(lag),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_slave(req_slave), .req_remote_addr(req_remote_addr),
    .req_remote_type(req_remote_type), .req_bytes(req_bytes), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_done(rx_done), .rx_fault(rx_fault));

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_mem(input logic [15:0] addr, input logic [15:0] exp);
    @(negedge clock);
    mem_rd_addr = addr;
    @(negedge clock);
    chk(mem_rd_data, exp);
  endtask : rd_mem

  // drives one command; good ones get a second start held into busy to be refused
  task automatic run(input logic wr, input logic [15:0] desc, input logic [7:0] cnt,
                     input logic [2:0] typ, input logic alt, input logic good);
    @(negedge clock);
    {cmd_write, cmd_desc, cmd_bytes_bcd} = {wr, desc, cnt};
    {cmd_remote_type, cmd_alt_net} = {typ, alt};
    cmd_start = 1'b1;
    #1 chk(cmd_accept, 1'b1);
    @(negedge clock);
    chk(port_busy_flag, good);
    chk(cmd_accept, !good);
    cmd_start = 1'b0;
    if (good) chk(port_error_flag, 1'b0);
    for (waited = 0; waited < 400 && port_busy_flag !== 1'b0; waited++) @(negedge clock);
    @(negedge clock);
    chk(port_busy_flag, 1'b0);
  endtask : run

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (6000) @(posedge clock);
    n_errors++;
    stop_test;
  end

  initial begin
    {rst_b, cmd_start, cmd_write, cmd_alt_net, mem_load_we, mode, lag} = 11'h000;
    {cmd_desc, cmd_local_oct} = {16'hF201, 16'h0008};
    {cmd_remote_addr, mem_load_addr} = {16'h0100, 16'h0000};
    {mem_load_data, mem_rd_addr, map_index_oct, cmd_bytes_bcd, cmd_remote_type} = 59'h0;
    n_errors = 0;
    cmp_count = 0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    // octal 54 and octal 2100, then index zero
    map_index_oct = 16'h002C;
    #1 chk(map_coil_addr, 16'h0C2D);
    map_index_oct = 16'h0440;
    #1 chk(map_hold_addr, 17'h0A081);
    map_index_oct = 16'h0000;
    #1 chk({map_hold_addr, map_coil_addr}, {17'h09C41, 16'h0C01});
    $display("test map done");
    // descriptor, alternate-net limit, type and count refused
    run(1'b0, 16'hF112, 8'h03, 3'h2, 1'b0, 1'b0);
    chk(port_error_flag, 1'b1);
    run(1'b0, 16'hF295, 8'h03, 3'h2, 1'b1, 1'b0);
    chk(port_error_flag, 1'b1);
    run(1'b0, 16'hF212, 8'h03, 3'h0, 1'b0, 1'b0);
    chk(port_error_flag, 1'b1);
    run(1'b0, 16'hF212, 8'h1A, 3'h2, 1'b0, 1'b0);
    chk(port_error_flag, 1'b1);
    $display("test refusals done");
    @(negedge clock);
    mem_load_we = 1'b1;
    for (i = 0; i < 6; i++) begin
      {mem_load_addr, mem_load_data} = {16'(8 + i), 16'(16'hB0C0 + 16'h0101 * i)};
      @(negedge clock);
    end
    mem_load_we = 1'b0;
    run(1'b1, 16'hF299, 8'h12, 3'h4, 1'b0, 1'b1);
    chk(pm.seen_req, {1'b1, 7'h63, 3'h4, 16'h0100, 8'h0C});
    chk(pm.cap_n, 12);
    for (i = 0; i < 6; i++)
      chk({pm.cap[2*i+1], pm.cap[2*i]}, 16'(16'hB0C0 + 16'h0101 * i));
    $display("test write done");
    lag = 4'hA;
    run(1'b0, 16'hF212, 8'h03, 3'h2, 1'b0, 1'b1);
    chk(pm.seen_req, {1'b0, 7'h0C, 3'h2, 16'h0100, 8'h03});
    chk(pm.n_done, 2);
    rd_mem(16'h0008, 16'h2211);
    rd_mem(16'h0009, 16'hB133);
    rd_mem(16'h000A, 16'hB2C2);
    $display("test read done");
    mode = 2'h1;
    run(1'b0, 16'hF212, 8'h02, 3'h2, 1'b0, 1'b1);
    chk(port_error_flag, 1'b1);
    mode = 2'h2;
    lag = 4'h0;
    run(1'b0, 16'hF212, 8'h02, 3'h2, 1'b0, 1'b1);
    chk(port_error_flag, 1'b1);
    chk(waited >= TMO, 1'b1);
    $display("test faults done");
    stop_test;
  end
endmodule : testbench
`default_nettype wire
